// ### hdl/tws_pkg.sv
// Package of constants and types for the two-wire register access slave
package tws_pkg;

   // ==========================================================
   // Slave addresses (7-bit form of the 8-bit address bytes)
   localparam logic [6:0] TWS_ADDR_DEFAULT = 7'h10;
   localparam logic [6:0] TWS_ADDR_ALT     = 7'h18;

   // ==========================================================
   // Reset values
   localparam logic [15:0] TWS_PTR_RESET   = 16'h0000;

   // ==========================================================
   // Framing and counts
   localparam logic [3:0]  TWS_BITS_PER_BYTE = 4'h8;
   localparam int          TWS_SYNC_STAGES   = 2;

   // ==========================================================
   // Timing
   localparam int TWS_CLK_PERIOD_PS = 8000;
   localparam int TWS_HOLD_NS       = 300;
   localparam int TWS_HOLD_CYC      =
      (TWS_HOLD_NS * 1000 + TWS_CLK_PERIOD_PS - 1) / TWS_CLK_PERIOD_PS;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      TWS_ST_IDLE,
      TWS_ST_RECV,
      TWS_ST_ACK,
      TWS_ST_SEND,
      TWS_ST_MACK,
      TWS_ST_SKIP
   } tws_state_t;

   typedef enum logic [1:0] {
      TWS_K_SLAVE,
      TWS_K_HIGH,
      TWS_K_LOW,
      TWS_K_DATA
   } tws_kind_t;

endpackage

// ### hdl/tws_pins_if.sv
// Interface between the pin front end and the protocol core
`timescale 1ns/1ps
interface tws_pins_if;
   logic scl_rise;
   logic scl_fall;
   logic sda_s;
   logic start_ev;
   logic stop_ev;
   logic alt_sel;
   logic drive_low;

   modport fe (
      output scl_rise,
      output scl_fall,
      output sda_s,
      output start_ev,
      output stop_ev,
      output alt_sel,
      input  drive_low
   );

   modport core (
      input  scl_rise,
      input  scl_fall,
      input  sda_s,
      input  start_ev,
      input  stop_ev,
      input  alt_sel,
      output drive_low
   );
endinterface

// ### hdl/tws_pin_fe.sv
// Pin front end: synchronisers, edge and start/stop detection, held data drive
`timescale 1ns/1ps
module tws_pin_fe (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic scl_in,
   input  wire logic sda_in,
   input  wire logic alt_address_enable,
   input  wire logic alt_address_select,
   output logic      sda_oe,
   tws_pins_if.fe    p
);

   // ==========================================================
   // Synchronisers
   logic [3:0] raw;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [1:0] prev_q;
   logic [5:0] hold_cnt_q;

   assign raw = {alt_address_select, alt_address_enable, sda_in, scl_in};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               sync1_q[gi] <= 1'b1;
               sync2_q[gi] <= 1'b1;
            end else begin
               sync1_q[gi] <= raw[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev_q <= 2'h3;
      end else begin
         prev_q <= sync2_q[1:0];
      end
   end

   // ==========================================================
   // Events
   assign p.scl_rise = sync2_q[0] & ~prev_q[0];
   assign p.scl_fall = ~sync2_q[0] & prev_q[0];
   assign p.sda_s    = sync2_q[1];
   assign p.start_ev = sync2_q[0] & prev_q[0] & prev_q[1] & ~sync2_q[1];
   assign p.stop_ev  = sync2_q[0] & prev_q[0] & ~prev_q[1] & sync2_q[1];
   // [R12] Alternate address only when enabled
   assign p.alt_sel  = sync2_q[2] & sync2_q[3];

   // ==========================================================
   // Data drive, delayed past the clock fall for hold time
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sda_oe     <= 1'b0;
         hold_cnt_q <= 6'h00;
      end else if (p.drive_low == sda_oe) begin
         hold_cnt_q <= 6'h00;
      end else if (hold_cnt_q >= 6'(tws_pkg::TWS_HOLD_CYC - 1)) begin
         sda_oe     <= p.drive_low;
         hold_cnt_q <= 6'h00;
      end else begin
         hold_cnt_q <= hold_cnt_q + 6'h01;
      end
   end

endmodule

// ### hdl/tws_slave.sv
// Two-wire register access slave: protocol core and register port
//
// Notes on behaviour
// [R1] Dummy write of 16-bit address loads pointer
// [R2] Master repeats start, then reads one byte
// [R3] Master ends reads with no-ack, stop
// [R4] Internal pointer loaded and advanced per byte
// [R5] Read without address write uses pointer
// [R6] Acked read bytes continue from next address
// [R7] Write sends high then low address byte
// [R8] Single write: one data byte, then stop
// [R9] Sequential write stores at successive addresses
// [R10] Pointer advances after every eight data bits
// [R11] Ack address, both pointer bytes, write data
// [R12] Bits 7:1 address, bit 0 direction
// [R13] Unmatched address: no ack, ignore transfer
// [R14] Stop or restart ends write, pointer kept
`timescale 1ns/1ps
module tws_slave (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        alt_address_enable,
   input  wire logic        alt_address_select,
   output logic [15:0]      reg_addr,
   output logic [7:0]       reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [7:0]  reg_rdata,
   output logic             busy
);

   // ==========================================================
   // Front end
   tws_pins_if p ();

   tws_pin_fe u_fe (
      .clk_sys            (clk_sys),
      .rst                (rst),
      .scl_in             (scl_in),
      .sda_in             (sda_in),
      .alt_address_enable (alt_address_enable),
      .alt_address_select (alt_address_select),
      .sda_oe             (sda_oe),
      .p                  (p.fe)
   );

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;

   // ==========================================================
   // Declarations
   tws_pkg::tws_state_t state_q;
   tws_pkg::tws_kind_t  kind_q;
   logic [3:0]          cnt_q;
   logic [7:0]          rx_q;
   logic [7:0]          tx_q;
   logic                read_q;
   logic                mack_q;
   logic                drive_q;
   logic [15:0]         ptr_q;
   logic                rx_done;
   logic                matched;
   logic                acc_byte;
   logic                tx_done;
   logic                load_tx;

   function automatic logic addr_match(input logic [7:0] b, input logic alt);
      logic [6:0] want;
      want = alt ? tws_pkg::TWS_ADDR_ALT : tws_pkg::TWS_ADDR_DEFAULT;
      return b[7:1] == want;
   endfunction

   assign p.drive_low = drive_q;

   // ==========================================================
   // Decode
   always_comb begin
      rx_done  = (state_q == tws_pkg::TWS_ST_RECV) && p.scl_fall
                 && (cnt_q == tws_pkg::TWS_BITS_PER_BYTE);
      // [R12] Compare address bits only
      matched  = addr_match(rx_q, p.alt_sel);
      // [R13] Unmatched slave byte not accepted
      acc_byte = rx_done && ((kind_q != tws_pkg::TWS_K_SLAVE) || matched);
      tx_done  = (state_q == tws_pkg::TWS_ST_SEND) && p.scl_fall
                 && (cnt_q == tws_pkg::TWS_BITS_PER_BYTE);
      // [R6] Master ack fetches next byte
      load_tx  = p.scl_fall
                 && (((state_q == tws_pkg::TWS_ST_ACK) && read_q)
                     || ((state_q == tws_pkg::TWS_ST_MACK) && mack_q));
   end

   // ==========================================================
   // Protocol state machine
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= tws_pkg::TWS_ST_IDLE;
         kind_q  <= tws_pkg::TWS_K_SLAVE;
         cnt_q   <= 4'h0;
         rx_q    <= 8'h00;
         tx_q    <= 8'h00;
         read_q  <= 1'b0;
         mack_q  <= 1'b0;
         drive_q <= 1'b0;
      end else if (p.start_ev) begin
         // [R14] Restart ends current transfer
         state_q <= tws_pkg::TWS_ST_RECV;
         kind_q  <= tws_pkg::TWS_K_SLAVE;
         cnt_q   <= 4'h0;
         read_q  <= 1'b0;
         drive_q <= 1'b0;
      end else if (p.stop_ev) begin
         // [R14] Stop ends transfer
         state_q <= tws_pkg::TWS_ST_IDLE;
         drive_q <= 1'b0;
      end else begin
         case (state_q)
            tws_pkg::TWS_ST_RECV: begin
               if (p.scl_rise && (cnt_q < tws_pkg::TWS_BITS_PER_BYTE)) begin
                  rx_q  <= {rx_q[6:0], p.sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end
               if (acc_byte) begin
                  // [R11] Acknowledge accepted byte
                  drive_q <= 1'b1;
                  state_q <= tws_pkg::TWS_ST_ACK;
                  case (kind_q)
                     tws_pkg::TWS_K_SLAVE: begin
                        // [R12] Bit 0 selects direction
                        read_q <= rx_q[0];
                        kind_q <= tws_pkg::TWS_K_HIGH;
                     end
                     tws_pkg::TWS_K_HIGH: begin
                        kind_q <= tws_pkg::TWS_K_LOW;
                     end
                     default: begin
                        kind_q <= tws_pkg::TWS_K_DATA;
                     end
                  endcase
               end else if (rx_done) begin
                  // [R13] Stay off bus until next start
                  state_q <= tws_pkg::TWS_ST_SKIP;
               end
            end
            tws_pkg::TWS_ST_ACK: begin
               if (p.scl_fall) begin
                  cnt_q <= 4'h0;
                  if (read_q) begin
                     // [R5] Send byte at current pointer
                     drive_q <= ~reg_rdata[7];
                     tx_q    <= {reg_rdata[6:0], 1'b0};
                     state_q <= tws_pkg::TWS_ST_SEND;
                  end else begin
                     drive_q <= 1'b0;
                     state_q <= tws_pkg::TWS_ST_RECV;
                  end
               end
            end
            tws_pkg::TWS_ST_SEND: begin
               if (p.scl_rise) begin
                  cnt_q <= cnt_q + 4'h1;
               end
               if (tx_done) begin
                  drive_q <= 1'b0;
                  state_q <= tws_pkg::TWS_ST_MACK;
               end else if (p.scl_fall) begin
                  drive_q <= ~tx_q[7];
                  tx_q    <= {tx_q[6:0], 1'b0};
               end
            end
            tws_pkg::TWS_ST_MACK: begin
               if (p.scl_rise) begin
                  mack_q <= ~p.sda_s;
               end
               if (load_tx) begin
                  cnt_q   <= 4'h0;
                  drive_q <= ~reg_rdata[7];
                  tx_q    <= {reg_rdata[6:0], 1'b0};
                  state_q <= tws_pkg::TWS_ST_SEND;
               end else if (p.scl_fall) begin
                  // [R3] No-ack ends the read
                  state_q <= tws_pkg::TWS_ST_SKIP;
               end
            end
            tws_pkg::TWS_ST_IDLE: begin
               drive_q <= 1'b0;
            end
            tws_pkg::TWS_ST_SKIP: begin
               drive_q <= 1'b0;
            end
            default: begin
               state_q <= tws_pkg::TWS_ST_IDLE;
               drive_q <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Internal register pointer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ptr_q <= tws_pkg::TWS_PTR_RESET;
      end else if (acc_byte && (kind_q == tws_pkg::TWS_K_HIGH)) begin
         // [R1] High pointer byte loaded first
         ptr_q[15:8] <= rx_q;
      end else if (acc_byte && (kind_q == tws_pkg::TWS_K_LOW)) begin
         // [R7] Low pointer byte completes address
         ptr_q[7:0] <= rx_q;
      end else if ((acc_byte && (kind_q == tws_pkg::TWS_K_DATA)) || tx_done) begin
         // [R10] Advance after each data byte
         ptr_q <= ptr_q + 16'h0001;
      end
   end

   // ==========================================================
   // Register port
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_addr  <= tws_pkg::TWS_PTR_RESET;
         reg_wdata <= 8'h00;
         reg_wr    <= 1'b0;
         reg_rd    <= 1'b0;
         busy      <= 1'b0;
      end else begin
         // [R9] Each write byte stored at pointer
         reg_wr <= acc_byte && (kind_q == tws_pkg::TWS_K_DATA);
         reg_rd <= load_tx && !p.start_ev && !p.stop_ev;
         if (acc_byte && (kind_q == tws_pkg::TWS_K_DATA)) begin
            reg_wdata <= rx_q;
            reg_addr  <= ptr_q;
         end else if (!reg_wr) begin
            // [R4] Pointer presented to register core
            reg_addr <= ptr_q;
         end
         busy <= (state_q != tws_pkg::TWS_ST_IDLE);
      end
   end

endmodule

// ### tb/tws_slave_monitor.sv
// Port checker for the two-wire register access slave
`timescale 1ns/1ps
module tws_slave_monitor (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        alt_address_enable,
   input wire logic        alt_address_select,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        busy
);
   logic [15:0] nxt_q;
   // Address expected after a stored byte
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nxt_q <= 16'h0000;
      end else if (reg_wr) begin
         nxt_q <= reg_addr + 16'h0001;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_wr_pulse; reg_wr |=> !reg_wr; endproperty
   property p_rd_pulse; reg_rd |=> !reg_rd; endproperty
   property p_ack_hold; $rose(sda_oe) |-> sda_oe[*8]; endproperty
   property p_wr_adv; reg_wr |-> ##[2:6] (reg_addr == nxt_q); endproperty
   property p_od; sda_out == 1'h0; endproperty
   property p_oe_low; $changed(sda_oe) |-> !scl_in; endproperty
   property p_wr_ack; reg_wr |-> !sda_oe ##[30:45] sda_oe; endproperty
   property p_wr_busy; reg_wr |-> busy; endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("store strobe too long");
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe too long");
   a_ack_hold: assert property (p_ack_hold)
      else $error("data drive dropped early");
   a_wr_adv: assert property (p_wr_adv)
      else $error("address not advanced");
   a_od: assert property (p_od)
      else $error("data pin driven high");
   a_oe_low: assert property (p_oe_low)
      else $error("data drive moved while clock high");
   a_wr_ack: assert property (p_wr_ack)
      else $error("stored byte not acknowledged");
   a_wr_busy: assert property (p_wr_busy)
      else $error("store while idle");
   c_wr: cover property (reg_wr);
   c_rd: cover property (reg_rd);
   c_ack: cover property ($rose(sda_oe));
endmodule
bind tws_slave tws_slave_monitor tws_slave_monitor_inst (.clk_sys, .rst, .scl_in, .sda_in,
   .sda_out, .sda_oe, .alt_address_enable, .alt_address_select, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .busy);

// ### tb/tws_master_model.sv
// Bus master model driving the serial clock and data line
`timescale 1ns/1ps
module tws_master_model (
   input  wire logic clk_sys,
   input  wire logic sda,
   output logic      scl,
   output logic      m_oe
);
   initial begin
      scl = 1'h1;
      m_oe = 1'h0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic start();
      w(8);
      m_oe <= 1'h0;
      w(92);
      scl <= 1'h1;
      w(100);
      m_oe <= 1'h1;
      w(100);
      scl <= 1'h0;
   endtask
   task automatic stop();
      w(8);
      m_oe <= 1'h1;
      w(92);
      scl <= 1'h1;
      w(100);
      m_oe <= 1'h0;
      w(100);
   endtask
   task automatic bit_x(input logic b, output logic s);
      w(8);
      m_oe <= !b;
      w(92);
      scl <= 1'h1;
      w(100);
      s = sda;
      scl <= 1'h0;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_x(b[i], s);
      bit_x(1'h1, s);
      ack = !s;
   endtask
   // Ack to continue, none to end
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_x(1'h1, d[i]);
      bit_x(!ack, s);
   endtask
endmodule

// ### tb/tws_slave_tb.sv
// Self-checking bench for the two-wire register access slave
`timescale 1ns/1ps
module tws_slave_tb;
   logic        clk_sys;
   logic        rst;
   logic        en;
   logic        sel;
   logic        scl;
   logic        m_oe;
   logic        sda_oe;
   logic        sda;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic        busy;
   logic [7:0]  reg_rdata;
   logic [23:0] wq[$];
   logic        a;
   logic [7:0]  d;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          n_rd = 0;
   // Wired-and data line with pull-up
   assign sda = !(sda_oe | m_oe);
   assign reg_rdata = reg_addr[7:0] ^ 8'h5A;
   initial clk_sys = 1'h0;
   always #4 clk_sys = !clk_sys;
   tws_slave tws_slave_inst (.clk_sys, .rst, .scl_in(scl), .sda_in(sda), .sda_out(),
      .sda_oe, .alt_address_enable(en), .alt_address_select(sel), .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .busy);
   tws_master_model tws_master_model_inst (.clk_sys, .sda, .scl, .m_oe);
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (reg_wr === 1'h1)
         wq.push_back({reg_addr, reg_wdata});
      if (reg_rd === 1'h1)
         n_rd++;
      if (cyc == 60000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic st();
      tws_master_model_inst.start();
   endtask
   task automatic sp();
      tws_master_model_inst.stop();
   endtask
   task automatic wb(input logic [7:0] b, input logic ex);
      tws_master_model_inst.wbyte(b, a);
      chk(24'(a), 24'(ex));
   endtask
   task automatic rb(input logic ack, input logic [7:0] ex);
      tws_master_model_inst.rbyte(ack, d);
      chk(24'(d), 24'(ex));
   endtask
   task automatic t_write();
      st();
      chk(24'(busy), 24'h000001);
      wb(8'h20, 1'h1);
      wb(8'h12, 1'h1);
      wb(8'h34, 1'h1);
      wb(8'hAB, 1'h1);
      wb(8'hCD, 1'h1);
      sp();
      chk(24'(busy), 24'h000000);
      chk(24'(wq.size()), 24'h000002);
      chk(wq[0], 24'h1234AB);
      chk(wq[1], 24'h1235CD);
      wq.delete();
      $display("write test done");
   endtask
   task automatic t_rand_read();
      st();
      wb(8'h20, 1'h1);
      wb(8'h00, 1'h1);
      wb(8'h50, 1'h1);
      st();
      wb(8'h21, 1'h1);
      rb(1'h1, 8'h0A);
      rb(1'h0, 8'h0B);
      sp();
      chk(24'(wq.size()), 24'h000000);
      chk(24'(n_rd), 24'h000002);
      $display("random read test done");
   endtask
   task automatic t_cur_read();
      st();
      wb(8'h21, 1'h1);
      rb(1'h0, 8'h08);
      sp();
      chk(24'(n_rd), 24'h000003);
      $display("current read test done");
   endtask
   task automatic t_addr();
      st();
      wb(8'h30, 1'h0);
      sp();
      @(posedge clk_sys);
      en <= 1'h1;
      sel <= 1'h1;
      st();
      wb(8'h20, 1'h0);
      sp();
      st();
      wb(8'h31, 1'h1);
      rb(1'h0, 8'h09);
      sp();
      @(posedge clk_sys);
      sel <= 1'h0;
      st();
      wb(8'h21, 1'h1);
      rb(1'h0, 8'h0E);
      sp();
      chk(24'(wq.size()), 24'h000000);
      chk(24'(n_rd), 24'h000005);
      $display("address test done");
   endtask
   initial begin
      rst = 1'h1;
      en = 1'h0;
      sel = 1'h0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'h0;
      repeat (4) @(posedge clk_sys);
      t_write();
      t_rand_read();
      t_cur_read();
      t_addr();
      give_verdict();
   end
endmodule
